// ### src/qcp_counter.sv
/*
   Counting core of a panel counter: pin synchronisers, quadrature
   decoding, reset and pause handling, parameter bank, thresholds
   and display selection.
   Assumes a parameter port driven by the serial protocol engine and
   key strobes from a keypad scanner, both on this clock.
*/
`timescale 1ns/10ps
`include "qcp_regs.svh"
module qcp_counter #(
   parameter int CYCLES_PER_MS = `QCP_CLOCK_KHZ
) (
   input  wire logic                    clock,
   input  wire logic                    arst_n,
   input  wire logic                    clk_en,
   input  wire logic                    encoder_phase_a,
   input  wire logic                    encoder_phase_b,
   input  wire logic                    reset_pin,
   input  wire logic                    pause_pin,
   input  wire logic                    reset_key,
   input  wire logic                    enter_first_key,
   input  wire logic                    enter_second_key,
   input  wire logic [31:0]             edit_value,
   input  wire qcp_pkg::qcp_par_req_type par_req,
   output qcp_pkg::qcp_par_rsp_type     par_rsp,
   output logic [31:0]                  count_value,
   output logic [31:0]                  display_value,
   output logic                         show_revision,
   output logic [2:0]                   decimal_point,
   output logic [2:0]                   scaling_enable,
   output logic [31:0]                  first_threshold,
   output logic [31:0]                  second_threshold,
   output logic                         output_one,
   output logic                         output_two
);
   // Arbitrary revision value
   localparam logic [31:0] FIRMWARE_REVISION = 32'h00000100;
   localparam int          REVISION_TICKS    = `QCP_REVISION_MS;

   logic [15:0] quadrature_multiplier;
   logic [15:0] max_input_rate_select;
   logic [15:0] debounce_time;
   logic [15:0] count_direction;
   logic [15:0] input_polarity_select;
   logic [15:0] decimal_point_place;
   logic [15:0] panel_lock;
   logic [15:0] reset_edge_select;
   logic [15:0] reset_offset_low;
   logic [15:0] reset_offset_high;
   logic [15:0] scaling_type;

   logic [3:0]  sync_1;
   logic [3:0]  sync_2;
   logic [3:0]  pin_active;
   logic [17:0] ms_count;
   logic        ms_tick;
   logic        reset_level, pause_level, reset_prev;
   logic        reset_pin_event, reset_key_event, manual_reset;
   logic        step_up, step_down;
   logic [31:0] offset_value;
   logic [31:0] next_count;
   logic [9:0]  revision_ms;
   logic        write_ok, addr_hit;
   logic [15:0] read_word, field_max;
   qcp_pkg::qcp_screen_type screen;
   qcp_pkg::qcp_phase_type  phase_mode;

   function automatic logic [11:0] rate_filter(input logic [15:0] code);
      int khz;
      case (code)
         16'h0000: khz = `QCP_RATE0_KHZ;
         16'h0001: khz = `QCP_RATE1_KHZ;
         16'h0002: khz = `QCP_RATE2_KHZ;
         16'h0003: khz = `QCP_RATE3_KHZ;
         default:  khz = `QCP_RATE4_KHZ;
      endcase
      // Eighth of a period keeps the filter well inside a half cycle
      return 12'(`QCP_CLOCK_KHZ / (khz * `QCP_FILTER_DIV));
   endfunction

   function automatic logic locks_first(input logic [15:0] code);
      return code == `QCP_LOCK_BOTH || code == `QCP_LOCK_FULL || code == `QCP_LOCK_FIRST;
   endfunction

   function automatic logic locks_second(input logic [15:0] code);
      return code == `QCP_LOCK_BOTH || code == `QCP_LOCK_FULL || code == `QCP_LOCK_SECOND;
   endfunction

   // Pin synchronisers: first stage feeds only the second
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sync_1 <= 4'h0;
         sync_2 <= 4'h0;
      end else if (clk_en) begin
         sync_1 <= {pause_pin, reset_pin, encoder_phase_b, encoder_phase_a};
         sync_2 <= sync_1;
      end
   end

   // Sinking inputs pull the line low when active
   assign pin_active = sync_2 ^ {4{input_polarity_select == 16'h0000}};

   assign phase_mode = quadrature_multiplier == 16'h0000 ? qcp_pkg::QCP_X1 :
                       quadrature_multiplier == 16'h0001 ? qcp_pkg::QCP_X2 :
                       qcp_pkg::QCP_X4;

   qcp_quad_decode u_decode (
      .clock         (clock),
      .arst_n        (arst_n),
      .clk_en        (clk_en),
      .phase_a       (pin_active[0]),
      .phase_b       (pin_active[1]),
      .mode          (phase_mode),
      .filter_cycles (rate_filter(max_input_rate_select)),
      .step_up       (step_up),
      .step_down     (step_down)
   );

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ms_count <= 18'h00000;
         ms_tick  <= 1'b0;
      end else if (clk_en) begin
         ms_tick <= ms_count == 18'(CYCLES_PER_MS - 1);
         if (ms_count == 18'(CYCLES_PER_MS - 1)) begin
            ms_count <= 18'h00000;
         end else begin
            ms_count <= ms_count + 18'h00001;
         end
      end
   end

   qcp_debounce u_reset_debounce (
      .clock     (clock),
      .arst_n    (arst_n),
      .clk_en    (clk_en),
      .ms_tick   (ms_tick),
      .hold_ms   (debounce_time[5:0]),
      .level_in  (pin_active[2]),
      .level_out (reset_level)
   );

   qcp_debounce u_pause_debounce (
      .clock     (clock),
      .arst_n    (arst_n),
      .clk_en    (clk_en),
      .ms_tick   (ms_tick),
      .hold_ms   (debounce_time[5:0]),
      .level_in  (pin_active[3]),
      .level_out (pause_level)
   );

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         reset_prev <= 1'b0;
      end else if (clk_en) begin
         reset_prev <= reset_level;
      end
   end

   assign reset_pin_event = reset_edge_select == 16'h0000 ? reset_level & ~reset_prev :
                            ~reset_level & reset_prev;
   assign reset_key_event = reset_key && panel_lock != `QCP_LOCK_RESET_KEY
                            && panel_lock != `QCP_LOCK_FULL;
   assign manual_reset    = reset_pin_event | reset_key_event;

   // Offset halves are written apart, so the limit is applied on use
   assign offset_value = {reset_offset_high, reset_offset_low} > `QCP_OFFSET_MAX ?
                         `QCP_OFFSET_MAX : {reset_offset_high, reset_offset_low};

   always_comb begin
      next_count = count_value;
      if (manual_reset) begin
         next_count = offset_value;
      end else if (!pause_level && (step_up ^ step_down)) begin
         if (step_up ^ (count_direction != 16'h0000)) begin
            next_count = count_value + 32'h00000001;
         end else begin
            next_count = count_value - 32'h00000001;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         count_value <= 32'h00000000;
      end else if (clk_en) begin
         count_value <= next_count;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         first_threshold  <= 32'h00000000;
         second_threshold <= 32'h00000000;
      end else if (clk_en) begin
         if (enter_first_key && !locks_first(panel_lock)) begin
            first_threshold <= edit_value;
         end
         if (enter_second_key && !locks_second(panel_lock)) begin
            second_threshold <= edit_value;
         end
      end
   end

   // Outputs latch until the next manual reset
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         output_one <= 1'b0;
         output_two <= 1'b0;
      end else if (clk_en) begin
         if (manual_reset) begin
            output_one <= 1'b0;
            output_two <= 1'b0;
         end else begin
            if (next_count == first_threshold) begin
               output_one <= 1'b1;
            end
            if (next_count == second_threshold) begin
               output_two <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         screen      <= qcp_pkg::QCP_SHOW_REVISION;
         revision_ms <= 10'h000;
      end else if (clk_en) begin
         unique case (screen)
            qcp_pkg::QCP_SHOW_REVISION: begin
               if (ms_tick) begin
                  revision_ms <= revision_ms + 10'h001;
               end
               if (revision_ms == 10'(REVISION_TICKS - 1) && ms_tick) begin
                  screen <= qcp_pkg::QCP_SHOW_COUNT;
               end
            end
            qcp_pkg::QCP_SHOW_COUNT: begin
               revision_ms <= 10'h000;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         show_revision  <= 1'b1;
         display_value  <= 32'h00000000;
         decimal_point  <= 3'h0;
         scaling_enable <= 3'h0;
      end else if (clk_en) begin
         show_revision  <= screen == qcp_pkg::QCP_SHOW_REVISION;
         display_value  <= screen == qcp_pkg::QCP_SHOW_REVISION ?
                           FIRMWARE_REVISION : next_count;
         decimal_point  <= decimal_point_place[2:0];
         scaling_enable <= 3'h1 << scaling_type[1:0];
      end
   end

   // Parameter bank: out-of-range codes are refused, not clamped
   always_comb begin
      addr_hit  = 1'b1;
      read_word = 16'h0000;
      field_max = 16'hFFFF;
      unique case (par_req.addr)
         `QCP_ADDR_PHASE_MODE: begin
            read_word = quadrature_multiplier;
            field_max = `QCP_MAX_PHASE;
         end
         `QCP_ADDR_MAX_RATE: begin
            read_word = max_input_rate_select;
            field_max = `QCP_MAX_RATE;
         end
         `QCP_ADDR_DEBOUNCE: begin
            read_word = debounce_time;
            field_max = `QCP_DEBOUNCE_MAX_MS;
         end
         `QCP_ADDR_DIRECTION: begin
            read_word = count_direction;
            field_max = `QCP_MAX_DIRECTION;
         end
         `QCP_ADDR_POLARITY: begin
            read_word = input_polarity_select;
            field_max = `QCP_MAX_POLARITY;
         end
         `QCP_ADDR_DECIMAL_POINT: begin
            read_word = decimal_point_place;
            field_max = `QCP_MAX_DECIMAL_POINT;
         end
         `QCP_ADDR_PANEL_LOCK: begin
            read_word = panel_lock;
            field_max = `QCP_MAX_PANEL_LOCK;
         end
         `QCP_ADDR_RESET_EDGE: begin
            read_word = reset_edge_select;
            field_max = `QCP_MAX_RESET_EDGE;
         end
         `QCP_ADDR_OFFSET_LOW:  read_word = reset_offset_low;
         `QCP_ADDR_OFFSET_HIGH: read_word = reset_offset_high;
         `QCP_ADDR_SCALING: begin
            read_word = scaling_type;
            field_max = `QCP_MAX_SCALING;
         end
         default: addr_hit = 1'b0;
      endcase
   end

   assign write_ok = par_req.wr && addr_hit && par_req.wdata <= field_max
                     && (par_req.addr != `QCP_ADDR_DEBOUNCE
                         || par_req.wdata >= `QCP_DEBOUNCE_MIN_MS);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         quadrature_multiplier <= 16'h0000;
         max_input_rate_select <= 16'h0000;
         debounce_time         <= `QCP_RESET_DEBOUNCE;
         count_direction       <= 16'h0000;
         input_polarity_select <= 16'h0000;
         decimal_point_place   <= 16'h0000;
         panel_lock            <= 16'h0000;
         reset_edge_select     <= 16'h0000;
         reset_offset_low      <= 16'h0000;
         reset_offset_high     <= 16'h0000;
         scaling_type          <= 16'h0000;
      end else if (clk_en && write_ok) begin
         unique case (par_req.addr)
            `QCP_ADDR_PHASE_MODE:    quadrature_multiplier <= par_req.wdata;
            `QCP_ADDR_MAX_RATE:      max_input_rate_select <= par_req.wdata;
            `QCP_ADDR_DEBOUNCE:      debounce_time         <= par_req.wdata;
            `QCP_ADDR_DIRECTION:     count_direction       <= par_req.wdata;
            `QCP_ADDR_POLARITY:      input_polarity_select <= par_req.wdata;
            `QCP_ADDR_DECIMAL_POINT: decimal_point_place   <= par_req.wdata;
            `QCP_ADDR_PANEL_LOCK:    panel_lock            <= par_req.wdata;
            `QCP_ADDR_RESET_EDGE:    reset_edge_select     <= par_req.wdata;
            `QCP_ADDR_OFFSET_LOW:    reset_offset_low      <= par_req.wdata;
            `QCP_ADDR_OFFSET_HIGH:   reset_offset_high     <= par_req.wdata;
            `QCP_ADDR_SCALING:       scaling_type          <= par_req.wdata;
            default:                 scaling_type          <= scaling_type;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         par_rsp <= '0;
      end else if (clk_en) begin
         par_rsp.ack   <= par_req.wr | par_req.rd;
         par_rsp.err   <= (par_req.wr | par_req.rd) && !(par_req.wr ? write_ok : addr_hit);
         par_rsp.rdata <= par_req.rd && addr_hit ? read_word : 16'h0000;
      end
   end
endmodule

// ### src/qcp_debounce.sv
/*
   Contact debouncer for one switch input.
   Assumes a synchronised input and a one-cycle millisecond tick.
*/
`timescale 1ns/10ps
module qcp_debounce (
   input  wire logic       clock,
   input  wire logic       arst_n,
   input  wire logic       clk_en,
   input  wire logic       ms_tick,
   input  wire logic [5:0] hold_ms,
   input  wire logic       level_in,
   output logic            level_out
);
   logic [5:0] elapsed;

   // Any bounce restarts the wait, so shorter pulses never pass
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         elapsed   <= 6'h00;
         level_out <= 1'b0;
      end else if (clk_en) begin
         if (level_in == level_out) begin
            elapsed <= 6'h00;
         end else if (elapsed >= hold_ms) begin
            level_out <= level_in;
            elapsed   <= 6'h00;
         end else if (ms_tick) begin
            elapsed <= elapsed + 6'h01;
         end
      end
   end
endmodule

// ### src/qcp_pkg.sv
/*
   Types of the quadrature counter core.
   Assumes the constants of qcp_regs.svh for field widths.
*/
package qcp_pkg;

   typedef enum logic [1:0] {QCP_X1, QCP_X2, QCP_X4} qcp_phase_type;

   typedef enum logic {QCP_SHOW_REVISION, QCP_SHOW_COUNT} qcp_screen_type;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } qcp_par_req_type;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [15:0] rdata;
   } qcp_par_rsp_type;

endpackage

// ### src/qcp_quad_decode.sv
/*
   Quadrature decoder with per-channel glitch filter.
   Assumes synchronised, polarity-corrected channel levels.
*/
`timescale 1ns/10ps
module qcp_quad_decode (
   input  wire logic                   clock,
   input  wire logic                   arst_n,
   input  wire logic                   clk_en,
   input  wire logic                   phase_a,
   input  wire logic                   phase_b,
   input  wire qcp_pkg::qcp_phase_type mode,
   input  wire logic [11:0]            filter_cycles,
   output logic                        step_up,
   output logic                        step_down
);
   logic [1:0]  raw;
   logic [1:0]  lvl;
   logic [1:0]  prev;
   logic [11:0] cnt [2];
   logic        a_rise, a_fall, b_rise, b_fall;
   logic        next_up, next_down;

   assign raw = {phase_b, phase_a};

   // Filter tuned to the rate band rejects noise above it
   for (genvar i = 0; i < 2; i++) begin : g_filter
      always_ff @(posedge clock or negedge arst_n) begin
         if (!arst_n) begin
            cnt[i] <= 12'h000;
            lvl[i] <= 1'b0;
         end else if (clk_en) begin
            if (raw[i] == lvl[i]) begin
               cnt[i] <= 12'h000;
            end else if (cnt[i] >= filter_cycles) begin
               lvl[i] <= raw[i];
               cnt[i] <= 12'h000;
            end else begin
               cnt[i] <= cnt[i] + 12'h001;
            end
         end
      end
   end

   assign a_rise = lvl[0] & ~prev[0];
   assign a_fall = ~lvl[0] & prev[0];
   assign b_rise = lvl[1] & ~prev[1];
   assign b_fall = ~lvl[1] & prev[1];

   always_comb begin
      next_up   = 1'b0;
      next_down = 1'b0;
      if (a_rise) begin
         next_up   = ~lvl[1];
         next_down = lvl[1];
      end else if (a_fall && mode != qcp_pkg::QCP_X1) begin
         next_up   = lvl[1];
         next_down = ~lvl[1];
      end else if (b_rise && mode == qcp_pkg::QCP_X4) begin
         next_up   = lvl[0];
         next_down = ~lvl[0];
      end else if (b_fall && mode == qcp_pkg::QCP_X4) begin
         next_up   = ~lvl[0];
         next_down = lvl[0];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         prev      <= 2'h0;
         step_up   <= 1'b0;
         step_down <= 1'b0;
      end else if (clk_en) begin
         prev      <= lvl;
         step_up   <= next_up;
         step_down <= next_down;
      end
   end
endmodule

// ### src/qcp_regs.svh
/*
   Constants of the quadrature counter core: parameter addresses,
   field limits, reset values and timing figures.
   Assumes a 200 MHz system clock and a parameter port addressed
   with the holding register numbers of the serial protocol.
*/
`ifndef QCP_REGS_SVH
`define QCP_REGS_SVH

`define QCP_ADDR_PHASE_MODE     16'h9C41
`define QCP_ADDR_MAX_RATE       16'h9C42
`define QCP_ADDR_DEBOUNCE       16'h9C43
`define QCP_ADDR_DIRECTION      16'h9C44
`define QCP_ADDR_POLARITY       16'h9C45
`define QCP_ADDR_DECIMAL_POINT  16'h9C46
`define QCP_ADDR_PANEL_LOCK     16'h9C47
`define QCP_ADDR_RESET_EDGE     16'h9C48
`define QCP_ADDR_OFFSET_LOW     16'h9C49
`define QCP_ADDR_OFFSET_HIGH    16'h9C4A
`define QCP_ADDR_SCALING        16'h9C4B

`define QCP_MAX_PHASE           16'h0002
`define QCP_MAX_RATE            16'h0004
`define QCP_MAX_DIRECTION       16'h0001
`define QCP_MAX_POLARITY        16'h0001
`define QCP_MAX_DECIMAL_POINT   16'h0004
`define QCP_MAX_PANEL_LOCK      16'h0005
`define QCP_MAX_RESET_EDGE      16'h0001
`define QCP_MAX_SCALING         16'h0002

`define QCP_RESET_DEBOUNCE      16'h000A
`define QCP_DEBOUNCE_MIN_MS     16'h0002
`define QCP_DEBOUNCE_MAX_MS     16'h0032
`define QCP_OFFSET_MAX          32'h000F423F

`define QCP_LOCK_RESET_KEY      16'h0001
`define QCP_LOCK_BOTH           16'h0002
`define QCP_LOCK_FULL           16'h0003
`define QCP_LOCK_FIRST          16'h0004
`define QCP_LOCK_SECOND         16'h0005

`define QCP_CLOCK_KHZ           200000
`define QCP_REVISION_MS         1000
`define QCP_FILTER_DIV          8
`define QCP_RATE0_KHZ           200
`define QCP_RATE1_KHZ           100
`define QCP_RATE2_KHZ           50
`define QCP_RATE3_KHZ           25
`define QCP_RATE4_KHZ           12

`endif

// ### test/qcp_counter_chk.sv
/*
   Port checker of the counter core.
   Assumes binding into qcp_counter with one clock domain.
*/
`timescale 1ns/10ps
module qcp_counter_chk (
   input wire logic                     clock,
   input wire logic                     arst_n,
   input wire logic                     clk_en,
   input wire qcp_pkg::qcp_par_req_type par_req,
   input wire qcp_pkg::qcp_par_rsp_type par_rsp,
   input wire logic [31:0]              count_value,
   input wire logic [31:0]              first_threshold,
   input wire logic                     enter_first_key,
   input wire logic                     output_one,
   input wire logic                     show_revision,
   input wire logic [2:0]               decimal_point,
   input wire logic [2:0]               scaling_enable
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   a_ack_next_edge: assert property (clk_en && (par_req.wr || par_req.rd) |=> par_rsp.ack)
      else $error("request not answered on the next edge");
   a_ack_has_cause: assert property (par_rsp.ack |-> $past(par_req.wr || par_req.rd))
      else $error("answer without request");
   a_err_with_ack: assert property (par_rsp.err |-> par_rsp.ack)
      else $error("refusal without answer");
   a_rdata_quiet: assert property (!par_rsp.ack |-> par_rsp.rdata == 16'h0000)
      else $error("read data outside answer");
   a_point_range: assert property (decimal_point <= 3'h4)
      else $error("decimal point code out of range");
   // Outputs hold their reset value on the first edge after release
   a_scale_onehot: assert property ($past(arst_n, 2) |-> $onehot(scaling_enable))
      else $error("scaling enable not one-hot");
   a_thr_commit: assert property ($changed(first_threshold) |-> $past(enter_first_key))
      else $error("threshold changed without enter");
   a_out_at_thr: assert property ($rose(output_one) |-> count_value == first_threshold)
      else $error("output one rose away from threshold");
   a_boot_once: assert property (!show_revision |=> !show_revision)
      else $error("revision screen came back");
endmodule

// ### test/qcp_enc_model.sv
/*
   Encoder and switch model: one quadrature step per request.
   Assumes requests change on the falling clock edge.
*/
`timescale 1ns/10ps
module qcp_enc_model (
   input  wire logic clock,
   input  wire logic sourcing,
   input  wire logic step_fwd,
   input  wire logic step_back,
   input  wire logic reset_on,
   input  wire logic pause_on,
   output logic      encoder_phase_a,
   output logic      encoder_phase_b,
   output logic      reset_pin,
   output logic      pause_pin
);
   logic [1:0] phase = 2'h0;
   // Gray order, A leads B going forward; back adds three
   always @(posedge clock) begin
      phase <= phase + {step_back, step_fwd | step_back};
   end
   // Sinking sensors pull the pin low while active
   assign encoder_phase_a = (phase[1] ^ phase[0]) ~^ sourcing;
   assign encoder_phase_b = phase[1] ~^ sourcing;
   assign reset_pin = reset_on ~^ sourcing;
   assign pause_pin = pause_on ~^ sourcing;
endmodule

// ### test/quadrature_counter_with_presets_tb_top.sv
/*
   Self-checking bench of the counter core with encoder model.
   Assumes CYCLES_PER_MS of 10 and rate code 0 filter times.
*/
`timescale 1ns/10ps
module quadrature_counter_with_presets_tb_top;
   logic                     clock = 1'b0;
   logic                     arst_n = 1'b0;
   logic                     clk_en = 1'b1;
   logic                     reset_key = 1'b0;
   logic                     enter_first_key = 1'b0;
   logic                     enter_second_key = 1'b0;
   logic [31:0]              edit_value = 32'h0;
   qcp_pkg::qcp_par_req_type par_req = '0;
   qcp_pkg::qcp_par_rsp_type par_rsp;
   logic                     step_fwd = 1'b0, step_back = 1'b0;
   logic                     reset_on = 1'b0, pause_on = 1'b0;
   logic                     sourcing = 1'b0;
   logic                     pa, pb, prst, ppause, show_revision, output_one;
   logic [31:0]              count_value, display_value, thr1, thr2;
   logic [2:0]               decimal_point, scaling_enable;
   int                       fails = 0, checks = 0;
   always #2.5 clock = ~clock;
   qcp_enc_model partner (.clock, .sourcing, .step_fwd, .step_back, .reset_on, .pause_on,
      .encoder_phase_a(pa), .encoder_phase_b(pb), .reset_pin(prst), .pause_pin(ppause));
   qcp_counter #(.CYCLES_PER_MS(10)) dut (.clock, .arst_n, .clk_en, .encoder_phase_a(pa),
      .encoder_phase_b(pb), .reset_pin(prst), .pause_pin(ppause), .reset_key, .enter_first_key,
      .enter_second_key, .edit_value, .par_req, .par_rsp, .count_value, .display_value,
      .show_revision, .decimal_point, .scaling_enable, .first_threshold(thr1),
      .second_threshold(thr2), .output_one, .output_two());
   task automatic summarize;
      if (fails == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic idle(int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic par(logic wr, logic [15:0] a, logic [15:0] d, logic err, logic [15:0] exp);
      @(negedge clock);
      par_req = '{wr, ~wr, a, d};
      @(negedge clock);
      par_req = '0;
      chk("answer", {30'h0, 1'b1, err}, {30'h0, par_rsp.ack, par_rsp.err});
      if (!wr) chk("read", {16'h0, exp}, {16'h0, par_rsp.rdata});
      @(negedge clock);
   endtask
   // Each step held well past the rate 0 glitch filter
   task automatic mv(int n);
      repeat (n < 0 ? -n : n) begin
         @(negedge clock);
         step_fwd = n > 0;
         step_back = n < 0;
         @(negedge clock);
         step_fwd = 1'b0;
         step_back = 1'b0;
         idle(300);
      end
   endtask
   task automatic keys(logic r, logic e);
      @(negedge clock);
      reset_key = r;
      enter_first_key = e;
      enter_second_key = e;
      @(negedge clock);
      reset_key = 1'b0;
      enter_first_key = 1'b0;
      enter_second_key = 1'b0;
      @(negedge clock);
   endtask
   function automatic int mult(int m);
      return m == 0 ? 1 : m == 1 ? 2 : 4;
   endfunction
   // Lock bits: second threshold, first threshold, reset key
   function automatic logic [2:0] locks(int lk);
      case (lk)
         1: return 3'h1;
         2: return 3'h6;
         3: return 3'h7;
         4: return 3'h2;
         5: return 3'h4;
         default: return 3'h0;
      endcase
   endfunction
   initial begin
      int unsigned k, off, v, c0;
      logic [2:0] lb;
      static logic [15:0] bad_a [5] = '{16'h9C40, 16'h9C42, 16'h9C43, 16'h9C43, 16'h9C4B};
      static logic [15:0] bad_d [5] = '{16'h0001, 16'h0005, 16'h0001, 16'h0033, 16'h0003};
      void'($urandom(91952));
      idle(12);
      arst_n = 1'b1;
      chk("show_revision", 32'h1, {31'h0, show_revision});
      for (int i = 0; i < 11; i++) par(1'b0, 16'h9C41 + 16'(i), 16'h0, 1'b0, i == 2 ? 16'h000A : 16'h0);
      for (int i = 0; i < 5; i++) par(1'b1, bad_a[i], bad_d[i], 1'b1, 16'h0);
      par(1'b0, 16'h9C43, 16'h0, 1'b0, 16'h000A);
      for (int i = 0; i < 5; i++) begin
         par(1'b1, 16'h9C46, 16'(i), 1'b0, 16'h0);
         chk("decimal_point", i, {29'h0, decimal_point});
         par(1'b1, 16'h9C42, 16'(4 - i), 1'b0, 16'h0);
         par(1'b0, 16'h9C42, 16'h0, 1'b0, 16'(4 - i));
      end
      for (int i = 0; i < 3; i++) begin
         par(1'b1, 16'h9C4B, 16'(i), 1'b0, 16'h0);
         chk("scaling_enable", 1 << i, {29'h0, scaling_enable});
      end
      for (int m = 0; m < 3; m++) begin
         for (int d = 0; d < 2; d++) begin
            par(1'b1, 16'h9C41, 16'(m), 1'b0, 16'h0);
            par(1'b1, 16'h9C44, 16'(d), 1'b0, 16'h0);
            k = 1 + $urandom % 3;
            c0 = count_value;
            mv(4 * k);
            mv(-4);
            v = (k - 1) * mult(m);
            chk("count_value", d ? c0 - v : c0 + v, count_value);
         end
      end
      par(1'b1, 16'h9C44, 16'h0, 1'b0, 16'h0);
      par(1'b1, 16'h9C45, 16'h0001, 1'b0, 16'h0);
      sourcing = 1'b1;
      pause_on = 1'b1;
      idle(150);
      c0 = count_value;
      mv(4);
      chk("count_value", c0, count_value);
      pause_on = 1'b0;
      idle(150);
      off = $urandom % 1000000;
      par(1'b1, 16'h9C49, off[15:0], 1'b0, 16'h0);
      par(1'b1, 16'h9C4A, off[31:16], 1'b0, 16'h0);
      reset_on = 1'b1;
      idle(150);
      chk("count_value", off, count_value);
      mv(1);
      reset_on = 1'b0;
      idle(150);
      chk("count_value", off + 1, count_value);
      par(1'b1, 16'h9C48, 16'h0001, 1'b0, 16'h0);
      reset_on = 1'b1;
      idle(3);
      reset_on = 1'b0;
      idle(150);
      chk("count_value", off + 1, count_value);
      reset_on = 1'b1;
      idle(150);
      chk("count_value", off + 1, count_value);
      reset_on = 1'b0;
      idle(150);
      chk("count_value", off, count_value);
      for (int lk = 0; lk < 6; lk++) begin
         par(1'b1, 16'h9C47, 16'(lk), 1'b0, 16'h0);
         lb = locks(lk);
         mv(1);
         c0 = count_value;
         keys(1'b1, 1'b0);
         chk("count_value", lb[0] ? c0 : off, count_value);
         v = $urandom % 1000000;
         c0 = thr1;
         k = thr2;
         edit_value = v;
         keys(1'b0, 1'b1);
         chk("first_threshold", lb[1] ? c0 : v, thr1);
         chk("second_threshold", lb[2] ? k : v, thr2);
      end
      edit_value = count_value + 2;
      keys(1'b0, 1'b1);
      chk("output_one", 32'h0, {31'h0, output_one});
      mv(2);
      chk("output_one", 32'h1, {31'h0, output_one});
      chk("show_revision", 32'h0, {31'h0, show_revision});
      chk("display_value", count_value, display_value);
      summarize;
   end
   // Tests need about 20000 to 34000 cycles
   initial begin
      #400000;
      fails++;
      summarize;
   end
endmodule
bind qcp_counter qcp_counter_chk u_chk (.clock, .arst_n, .clk_en, .par_req, .par_rsp,
   .count_value, .first_threshold, .enter_first_key, .output_one, .show_revision,
   .decimal_point, .scaling_enable);
